// *** core/pcie_capability_device_link_regs.v ***
// Device and link portion of the PCIe capability register bank.
// Assumes: config accesses arrive as one-cycle strobes synchronous to
// I_CORE_CLK; error, transaction and aux power events from the core.
//
// What this block does
// - Endpoint L1 acceptable latency reads 100b
// - Endpoint L0s acceptable latency reads 100b
// - No extended tags, no phantom functions
// - Max payload supported reads 512 bytes
// - Initiate FLR bit reads zero
// - Writable read request size, reset 010b
// - Aux power PM enable is sticky
// - Phantom and extended tag enables stay zero
// - Max payload fixed at 128 bytes
// - Relaxed ordering enable resets to one
// - Four error reporting enables, reset zero
// - Transactions pending while non-posted outstanding
// - Aux power detected gated by enable
// - Error detected bits set only while their reporting enable is on, write-one clears
// - Port number reads 00h, read-only
// - L1 and L0s exit latency codes 101b
// - ASPM support advertises L0s only
// - One lane, 2.5Gbps maximum speed
// - Two link bandwidth interrupt enables
// - Extended sync sets long ordered set counts
// - Common clock configuration bit is writable
// - Unsupported link control bits read zero
// - ASPM control field, four encodings
`timescale 1ns/100ps
`include "pcie_cap_map.vh"
module pcie_capability_device_link_regs (
  input wire I_CORE_CLK, // Core clock, 250 MHz
  input wire I_NRST, // Fundamental reset, active low
  input wire I_POWER_ON_NRST, // Power-on reset for sticky bits, low
  input wire I_CE, // Clock enable
  input wire I_CFG_WR, // Config write strobe
  input wire I_CFG_RD, // Config read strobe
  input wire [7:0] I_CFG_ADDR, // Byte offset, dword aligned
  input wire [3:0] I_CFG_BE, // Byte enables
  input wire [31:0] I_CFG_WDATA, // Write data
  input wire [7:0] I_SLOT_PWR_VAL, // Captured slot power limit value
  input wire [1:0] I_SLOT_PWR_SCALE, // Captured slot power limit scale
  input wire I_NP_ISSUE, // Non-posted request issued pulse
  input wire I_NP_DONE, // Non-posted completed or timed out
  input wire I_AUX_PRESENT, // Aux power sensed
  input wire [3:0] I_ERR_EVENT, // UR, fatal, nonfatal, correctable
  output reg [31:0] O_CFG_RDATA, // Read data
  output reg O_CFG_ACK, // Access done pulse
  output reg [3:0] O_ERR_REPORT, // Error class report pulses
  output reg [2:0] O_MAX_READ_REQ, // Read request size code
  output reg [2:0] O_MAX_PAYLOAD, // Payload size code
  output reg O_RELAXED_ORDER, // Relaxed ordering allowed
  output reg O_NO_SNOOP, // No snoop allowed
  output reg O_AUX_PM_EN, // Aux power use enabled
  output reg [1:0] O_ASPM_CTRL, // ASPM entry enables
  output reg O_COMMON_CLK, // Shared reference clock
  output reg O_ABW_INT_EN, // Autonomous bandwidth irq enable
  output reg O_BWM_INT_EN, // Bandwidth management irq enable
  output reg O_EXT_SYNC, // Extended sync selected
  output reg [12:0] O_FTS_COUNT, // FTS sets for L0s exit
  output reg [10:0] O_TS1_COUNT, // TS1 sets before Recovery
  output reg O_SKP_BEFORE_L0 // One SKP before L0
);

  // Reset release synchronisers
  reg rst_meta;
  reg rst_n;
  reg por_meta;
  reg por_n;
  // Device control state
  reg [2:0] mrrs; // Read request size
  reg no_snoop; // No snoop enable
  reg aux_pm_en; // Sticky aux enable
  reg relax; // Relaxed ordering enable
  reg [3:0] err_en; // Reporting enables
  // Link control state
  reg abw_ie; // Autonomous bandwidth irq enable
  reg bwm_ie; // Bandwidth management irq enable
  reg ext_sync; // Extended sync
  reg ccc; // Common clock configuration
  reg [1:0] aspm; // ASPM control
  // Transactions outstanding counter
  reg [5:0] np_cnt;
  reg [5:0] next_np_cnt;
  // Error flags from the leaf instances
  wire [3:0] err_flag_q;
  wire [3:0] err_clear;
  // Decoded write strobes
  wire wr_dctl;
  wire wr_lctl;
  wire wr_dsts;
  // Assembled register images
  wire [31:0] dcap_img;
  wire [15:0] dctl_img;
  wire [15:0] dsts_img;
  wire [31:0] lcap_img;
  wire [15:0] lctl_img;

  // Decode one offset; shared by write and read paths
  // Only the dword index is compared; the low address bits are
  // ignored because byte lanes arrive on the enables instead
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // Main reset release, two flops
  // Assertion reaches every rst_n flop at once, but release is retimed so
  // no register leaves reset on a different edge from its neighbours
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Power-on reset release, two flops
  // Kept apart from the main reset so the sticky enable survives a
  // fundamental reset issued while the device stays powered
  always @(posedge I_CORE_CLK or negedge I_POWER_ON_NRST) begin
    if (!I_POWER_ON_NRST) begin
      por_meta <= 1'b0;
      por_n <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_n <= por_meta;
    end
  end

  // Device control and status share one dword; status is the upper half
  // Status clears need byte lane 2; lane 3 holds only reserved bits
  assign wr_dctl = I_CFG_WR && hit(I_CFG_ADDR, `OFS_DEVICE_CONTROL);
  assign wr_dsts = wr_dctl && I_CFG_BE[2];
  assign wr_lctl = I_CFG_WR && hit(I_CFG_ADDR, `OFS_LINK_CONTROL);

  assign err_clear = wr_dsts ? I_CFG_WDATA[19:16] : 4'h0;

  // Writable device control fields
  // Each byte lane gates its own fields so partial writes are safe
  // Payload size has no flop: it is fixed and writes are dropped
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mrrs <= `DCTL_MRRS_RST;
      no_snoop <= 1'b0;
      relax <= `DCTL_RELAX_RST;
      err_en <= 4'h0;
    end else if (I_CE && wr_dctl) begin
      if (I_CFG_BE[1]) begin
        if (I_CFG_WDATA[14:12] <= `DCTL_MRRS_MAX) begin
          mrrs <= I_CFG_WDATA[14:12];
        end
        no_snoop <= I_CFG_WDATA[`DCTL_NOSNOOP_BIT];
      end
      if (I_CFG_BE[0]) begin
        relax <= I_CFG_WDATA[`DCTL_RELAX_BIT];
        err_en <= I_CFG_WDATA[3:0];
      end
    end
  end

  // Sticky aux enable survives fundamental resets
  // Writes are ignored while the main reset is still being released
  always @(posedge I_CORE_CLK or negedge por_n) begin
    if (!por_n) begin
      aux_pm_en <= 1'b0;
    end else if (I_CE && rst_n && wr_dctl && I_CFG_BE[1]) begin
      aux_pm_en <= I_CFG_WDATA[`DCTL_AUXPM_BIT];
    end
  end

  // Writable link control fields
  // Retrain, link disable and completion boundary have no storage
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      abw_ie <= 1'b0;
      bwm_ie <= 1'b0;
      ext_sync <= 1'b0;
      ccc <= 1'b0;
      aspm <= 2'h0;
    end else if (I_CE && wr_lctl) begin
      if (I_CFG_BE[1]) begin
        abw_ie <= I_CFG_WDATA[`LCTL_ABW_IE_BIT];
        bwm_ie <= I_CFG_WDATA[`LCTL_BWM_IE_BIT];
      end
      if (I_CFG_BE[0]) begin
        ext_sync <= I_CFG_WDATA[`LCTL_EXT_SYNC_BIT];
        ccc <= I_CFG_WDATA[`LCTL_CCC_BIT];
        aspm <= I_CFG_WDATA[1:0];
      end
    end
  end

  // Outstanding count; issue and finish in one cycle cancel out
  // Limitation: a finish with nothing outstanding is dropped, so a
  // stray completion cannot wrap the count and fake a pending flag
  always @* begin
    next_np_cnt = np_cnt;
    if (I_NP_ISSUE && !I_NP_DONE) begin
      next_np_cnt = np_cnt + 6'h01;
    end else if (!I_NP_ISSUE && I_NP_DONE && np_cnt != 6'h00) begin
      next_np_cnt = np_cnt - 6'h01;
    end
  end

  // Counter wide enough for 32 tags outstanding, no extended tags
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      np_cnt <= 6'h00;
    end else if (I_CE) begin
      np_cnt <= next_np_cnt;
    end
  end

  // Error detected flags, one leaf each
  // The leaf keeps set-over-clear priority in one place for all four
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_err
      err_flag u_err (
        .clk(I_CORE_CLK),
        .rst_n(rst_n),
        .ce(I_CE),
        .enable(err_en[g]),
        .event_in(I_ERR_EVENT[g]),
        .clear(err_clear[g]),
        .flag(err_flag_q[g])
      );
    end
  endgenerate

  assign dcap_img = {3'h0, 1'b0, I_SLOT_PWR_SCALE, I_SLOT_PWR_VAL, 2'h0, 1'b1, 3'h0,
                     `DCAP_L1_ACC_LAT, `DCAP_L0S_ACC_LAT, `DCAP_EXT_TAG,
                     `DCAP_PHANTOM, `DCAP_MAX_PAYLOAD};

  assign dctl_img = {1'b0, mrrs, no_snoop, aux_pm_en, 1'b0, 1'b0,
                     `DCTL_MPS_VAL, relax, err_en};

  assign dsts_img = {10'h000, (np_cnt != 6'h00), (aux_pm_en & I_AUX_PRESENT),
                     err_flag_q};

  assign lcap_img = {`LCAP_PORT_NUM, 6'h00, `LCAP_L1_EXIT, `LCAP_L0S_EXIT,
                     `LCAP_ASPM_SUP, `LCAP_MAX_WIDTH, `LCAP_MAX_SPEED};

  assign lctl_img = {4'h0, abw_ie, bwm_ie, 1'b0, 1'b0, ext_sync, ccc,
                     1'b0, 1'b0, 1'b0, 1'b0, aspm};

  // Read mux and access acknowledge; link status half reads zero here
  // Reads carry no side effects, so a repeated read is harmless
  // Writes are acknowledged too, which keeps the host side uniform
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_CFG_RDATA <= 32'h0000_0000;
      O_CFG_ACK <= 1'b0;
    end else if (I_CE) begin
      O_CFG_ACK <= I_CFG_RD | I_CFG_WR;
      if (I_CFG_RD) begin
        if (hit(I_CFG_ADDR, `OFS_DEVICE_CAPABILITIES)) begin
          O_CFG_RDATA <= dcap_img;
        end else if (hit(I_CFG_ADDR, `OFS_DEVICE_CONTROL)) begin
          O_CFG_RDATA <= {dsts_img, dctl_img};
        end else if (hit(I_CFG_ADDR, `OFS_LINK_CAPABILITIES)) begin
          O_CFG_RDATA <= lcap_img;
        end else if (hit(I_CFG_ADDR, `OFS_LINK_CONTROL)) begin
          O_CFG_RDATA <= {16'h0000, lctl_img};
        end else begin
          O_CFG_RDATA <= 32'h0000_0000;
        end
      end
    end
  end

  // Registered control outputs toward the transaction and link layers
  // Trade-off: one cycle of lag buys clean flop outputs at the boundary
  // so downstream logic never sees a decode glitch on a write
  always @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_ERR_REPORT <= 4'h0;
      O_MAX_READ_REQ <= `DCTL_MRRS_RST;
      O_MAX_PAYLOAD <= `DCTL_MPS_VAL;
      O_RELAXED_ORDER <= `DCTL_RELAX_RST;
      O_NO_SNOOP <= 1'b0;
      O_AUX_PM_EN <= 1'b0;
      O_ASPM_CTRL <= 2'h0;
      O_COMMON_CLK <= 1'b0;
      O_ABW_INT_EN <= 1'b0;
      O_BWM_INT_EN <= 1'b0;
      O_EXT_SYNC <= 1'b0;
      O_FTS_COUNT <= 13'h0000;
      O_TS1_COUNT <= 11'h000;
      O_SKP_BEFORE_L0 <= 1'b0;
    end else if (I_CE) begin
      O_ERR_REPORT <= I_ERR_EVENT & err_en;
      O_MAX_READ_REQ <= mrrs;
      O_MAX_PAYLOAD <= `DCTL_MPS_VAL;
      O_RELAXED_ORDER <= relax;
      O_NO_SNOOP <= no_snoop;
      O_AUX_PM_EN <= aux_pm_en;
      O_ASPM_CTRL <= aspm;
      O_COMMON_CLK <= ccc;
      O_ABW_INT_EN <= abw_ie;
      O_BWM_INT_EN <= bwm_ie;
      O_EXT_SYNC <= ext_sync;
      O_FTS_COUNT <= ext_sync ? `FTS_EXT_COUNT : 13'h0000;
      O_TS1_COUNT <= ext_sync ? `TS1_EXT_COUNT : 11'h000;
      O_SKP_BEFORE_L0 <= ext_sync;
    end
  end

endmodule

// *** include/pcie_cap_map.vh ***
// Constants for the device/link capability register bank.
// Assumes: included by bare name; byte offsets within the capability.
`ifndef PCIE_CAP_MAP_VH
`define PCIE_CAP_MAP_VH
// Register offsets (byte addresses within the capability)
`define OFS_DEVICE_CAPABILITIES 8'h04
`define OFS_DEVICE_CONTROL 8'h08
`define OFS_DEVICE_STATUS 8'h0A
`define OFS_LINK_CAPABILITIES 8'h0C
`define OFS_LINK_CONTROL 8'h10
// Device capabilities fixed fields
`define DCAP_L1_ACC_LAT 3'h4
`define DCAP_L0S_ACC_LAT 3'h4
`define DCAP_EXT_TAG 1'h0
`define DCAP_PHANTOM 2'h0
`define DCAP_MAX_PAYLOAD 3'h2
// Device control fields and resets
`define DCTL_MRRS_LSB 12
`define DCTL_MRRS_RST 3'h2
`define DCTL_MRRS_MAX 3'h5
`define DCTL_NOSNOOP_BIT 11
`define DCTL_AUXPM_BIT 10
`define DCTL_MPS_LSB 5
`define DCTL_MPS_VAL 3'h0
`define DCTL_RELAX_BIT 4
`define DCTL_RELAX_RST 1'h1
// Link capabilities fixed fields
`define LCAP_PORT_NUM 8'h00
`define LCAP_L1_EXIT 3'h5
`define LCAP_L0S_EXIT 3'h5
`define LCAP_ASPM_SUP 2'h1
`define LCAP_MAX_WIDTH 6'h01
`define LCAP_MAX_SPEED 4'h1
// Link control fields
`define LCTL_ABW_IE_BIT 11
`define LCTL_BWM_IE_BIT 10
`define LCTL_EXT_SYNC_BIT 7
`define LCTL_CCC_BIT 6
// Extended sync ordered set counts
`define FTS_EXT_COUNT 13'h1000
`define TS1_EXT_COUNT 11'h400
`endif

// *** core/err_flag.v ***
// One sticky error-detected flag with write-one-to-clear.
// Assumes: synchronous clock enable and async low reset from the parent.
`timescale 1ns/100ps
module err_flag (
  input wire clk, // Core clock
  input wire rst_n, // Synchronised reset, active low
  input wire ce, // Clock enable
  input wire enable, // Reporting enable
  input wire event_in, // Error detected pulse
  input wire clear, // Software write-one
  output reg flag // Sticky status
);
  // Set beats clear so an event in the clear cycle is kept
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (ce) begin
      if (enable && event_in) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

// *** verification/cap_regs_asserts.sv ***
// Port checker for the device/link capability register bank.
// Assumes: bound to the top module; one clock, reset I_NRST.
`timescale 1ns/100ps
module cap_regs_asserts (
  input wire I_CORE_CLK, // Core clock
  input wire I_NRST, // Reset, active low
  input wire I_CE, // Clock enable
  input wire I_CFG_WR, // Write strobe
  input wire I_CFG_RD, // Read strobe
  input wire [7:0] I_CFG_ADDR, // Byte offset
  input wire [3:0] I_ERR_EVENT, // Error pulses
  input wire [31:0] O_CFG_RDATA, // Read data
  input wire O_CFG_ACK, // Access done
  input wire [3:0] O_ERR_REPORT, // Report pulses
  input wire [2:0] O_MAX_READ_REQ, // Read request code
  input wire [2:0] O_MAX_PAYLOAD, // Payload code
  input wire O_EXT_SYNC, // Extended sync
  input wire [12:0] O_FTS_COUNT, // FTS count
  input wire [10:0] O_TS1_COUNT, // TS1 count
  input wire O_SKP_BEFORE_L0 // SKP flag
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_NRST);
  // Access taken, and a read of one dword
  wire acc = I_CE && (I_CFG_WR || I_CFG_RD);
  wire rd = I_CE && I_CFG_RD;
  a_ack_follows: assert property (acc |=> O_CFG_ACK)
    else $error("ack missing after access");
  a_ack_only_reply: assert property (!acc |=> !O_CFG_ACK)
    else $error("ack without access");
  a_payload_fixed: assert property (O_MAX_PAYLOAD == 3'h0)
    else $error("payload code not 128 bytes");
  a_rrs_legal: assert property (O_MAX_READ_REQ <= 3'h5)
    else $error("read request code reserved");
  a_report_quiet: assert property (I_CE && I_ERR_EVENT == 4'h0 |=> O_ERR_REPORT == 4'h0)
    else $error("report without error");
  a_fts_count: assert property (O_FTS_COUNT == (O_EXT_SYNC ? 13'h1000 : 13'h0000))
    else $error("fts count wrong");
  a_ts1_skp: assert property (O_TS1_COUNT == (O_EXT_SYNC ? 11'h400 : 11'h000)
    && O_SKP_BEFORE_L0 == O_EXT_SYNC)
    else $error("ts1 or skp wrong");
  a_linkcap_fixed: assert property (rd && I_CFG_ADDR[7:2] == 6'h03
    |=> (O_CFG_RDATA & 32'hFFBB_FFFF) == 32'h0002_D411)
    else $error("link capabilities wrong");
  a_linkctl_zero: assert property (rd && I_CFG_ADDR[7:2] == 6'h04
    |=> (O_CFG_RDATA & 32'hFFFF_F33C) == 32'h0000_0000)
    else $error("link control zero bits set");
  a_devctl_fixed: assert property (rd && I_CFG_ADDR[7:2] == 6'h02
    |=> (O_CFG_RDATA & 32'hFFC0_83E0) == 32'h0000_0000)
    else $error("device control fixed bits set");
endmodule
bind pcie_capability_device_link_regs cap_regs_asserts chk (.I_CORE_CLK(I_CORE_CLK),
  .I_NRST(I_NRST), .I_CE(I_CE), .I_CFG_WR(I_CFG_WR), .I_CFG_RD(I_CFG_RD),
  .I_CFG_ADDR(I_CFG_ADDR), .I_ERR_EVENT(I_ERR_EVENT), .O_CFG_RDATA(O_CFG_RDATA),
  .O_CFG_ACK(O_CFG_ACK), .O_ERR_REPORT(O_ERR_REPORT), .O_MAX_READ_REQ(O_MAX_READ_REQ),
  .O_MAX_PAYLOAD(O_MAX_PAYLOAD), .O_EXT_SYNC(O_EXT_SYNC), .O_FTS_COUNT(O_FTS_COUNT),
  .O_TS1_COUNT(O_TS1_COUNT), .O_SKP_BEFORE_L0(O_SKP_BEFORE_L0));

// *** verification/cfg_host_model.sv ***
// Configuration host model: single config reads and writes.
// Assumes: one-cycle strobes taken at the rising edge, ack one edge on.
`timescale 1ns/100ps
module cfg_host_model (
  input wire clk, // Core clock
  input wire ack, // Access done
  input wire [31:0] rdata, // Read data
  output logic wr = 1'b0, // Write strobe
  output logic rd = 1'b0, // Read strobe
  output logic [7:0] addr = 8'h00, // Byte offset
  output logic [3:0] be = 4'h0, // Byte enables
  output logic [31:0] wdata = 32'h0000_0000 // Write data
);
  // W1C clear is a write of ones
  task access(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] q, output logic k);
    begin
      @(negedge clk);
      wr = w;
      rd = !w;
      addr = a;
      be = b;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
      // Released lines show a changed pattern, not the old value
      addr = ~a;
      wdata = ~d;
      k = ack;
      q = rdata;
    end
  endtask
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the capability register bank.
// Assumes: host model file and design sources with their header.
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, por_n = 1'b0, np_is = 1'b0, np_dn = 1'b0, aux = 1'b1;
  logic ce = 1'b1;
  logic [3:0] ev = 4'h0, rep_seen;
  logic [31:0] q;
  logic k;
  wire wr, rd, ack, ro, ns, auxen, ccc, abw, bwm, xs, skp;
  wire [7:0] addr;
  wire [3:0] be, rep;
  wire [31:0] wdata, rdata;
  wire [2:0] mrrs, mps;
  wire [1:0] aspm;
  wire [12:0] fts;
  wire [10:0] ts1;
  int err_total = 0, n_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  cfg_host_model host (.clk(clk), .ack(ack), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr),
    .be(be), .wdata(wdata));
  pcie_capability_device_link_regs uut (.I_CORE_CLK(clk), .I_NRST(nrst),
    .I_POWER_ON_NRST(por_n), .I_CE(ce), .I_CFG_WR(wr), .I_CFG_RD(rd), .I_CFG_ADDR(addr),
    .I_CFG_BE(be), .I_CFG_WDATA(wdata), .I_SLOT_PWR_VAL(8'hA5), .I_SLOT_PWR_SCALE(2'h2),
    .I_NP_ISSUE(np_is), .I_NP_DONE(np_dn), .I_AUX_PRESENT(aux), .I_ERR_EVENT(ev),
    .O_CFG_RDATA(rdata), .O_CFG_ACK(ack), .O_ERR_REPORT(rep), .O_MAX_READ_REQ(mrrs),
    .O_MAX_PAYLOAD(mps), .O_RELAXED_ORDER(ro), .O_NO_SNOOP(ns), .O_AUX_PM_EN(auxen),
    .O_ASPM_CTRL(aspm), .O_COMMON_CLK(ccc), .O_ABW_INT_EN(abw), .O_BWM_INT_EN(bwm),
    .O_EXT_SYNC(xs), .O_FTS_COUNT(fts), .O_TS1_COUNT(ts1), .O_SKP_BEFORE_L0(skp));
  // Compare and count
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr32(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    host.access(1'b1, a, b, d, q, k);
  endtask
  // Read, then compare the unmasked bits and the ack
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    host.access(1'b0, a, 4'hF, 32'h0000_0000, q, k);
    check("ack", 32'(k), 32'h0000_0001);
    check("rdata", q & m, exp);
  endtask
  // Event pulses, report captured one edge on
  task pulse(input logic [3:0] e, input logic is, input logic dn);
    @(negedge clk);
    ev = e;
    np_is = is;
    np_dn = dn;
    @(negedge clk);
    rep_seen = rep;
    ev = 4'h0;
    np_is = 1'b0;
    np_dn = 1'b0;
  endtask
  // Reset for 16 cycles; po also clears the sticky bit
  task do_reset(input logic po);
    @(negedge clk);
    nrst = 1'b0;
    por_n = !po;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    por_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task complete_run;
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    do_reset(1'b1);
    rdchk(8'h04, 32'hFFFF_FFFF, 32'h0A94_8902);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h0000_2010);
    rdchk(8'h0C, 32'hFFBB_FFFF, 32'h0002_D411);
    rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
    pulse(4'hF, 1'b0, 1'b0);
    check("report off", 32'(rep_seen), 32'h0000_0000);
    wr32(8'h08, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h0010_2C1F);
    check("rrs kept", 32'(mrrs), 32'h0000_0002);
    check("aux en", 32'(auxen), 32'h0000_0001);
    check("ro ns mps", 32'({ro, ns, mps}), 32'h0000_0018);
    wr32(8'h08, 4'h3, 32'h0000_5C1F);
    @(negedge clk);
    check("rrs max", 32'(mrrs), 32'h0000_0005);
    pulse(4'hF, 1'b1, 1'b0);
    check("report on", 32'(rep_seen), 32'h0000_000F);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h003F_5C1F);
    wr32(8'h08, 4'h4, 32'h0000_0000);
    wr32(8'h08, 4'h4, 32'h0005_0000);
    pulse(4'h0, 1'b0, 1'b1);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h001A_5C1F);
    wr32(8'h10, 4'hF, 32'hFFFF_FFFF);
    rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0CC3);
    check("int en", 32'({abw, bwm, ccc}), 32'h0000_0007);
    check("fts", 32'(fts), 32'h0000_1000);
    check("ts1 skp", 32'({ts1, skp}), 32'h0000_0801);
    for (int i = 0; i < 4; i++) begin
      wr32(8'h10, 4'h3, 32'h0000_0C40 | i);
      @(negedge clk);
      check("aspm", 32'(aspm), i);
    end
    @(negedge clk);
    ce = 1'b0;
    wr32(8'h10, 4'h3, 32'h0000_0000);
    ce = 1'b1;
    rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0C43);
    check("no sync", 32'({xs, fts}), 32'h0000_0000);
    do_reset(1'b0);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h0010_2410);
    do_reset(1'b1);
    rdchk(8'h08, 32'hFFFF_FFFF, 32'h0000_2010);
    complete_run();
  end
endmodule
